// *** hw/scm_pkg.sv ***
// Constants for the system configuration clock and miscellaneous register bank
package scm_pkg;

  // Register byte addresses
  localparam logic [31:0] SCM_ADR_FRAC_DEN = 32'h4004_80D0;
  localparam logic [31:0] SCM_ADR_FRAC_NUM = 32'h4004_80D4;
  localparam logic [31:0] SCM_ADR_FRAC_SRC = 32'h4004_80D8;
  localparam logic [31:0] SCM_ADR_CO_SEL = 32'h4004_80F0;
  localparam logic [31:0] SCM_ADR_CO_DIV = 32'h4004_80F4;
  localparam logic [31:0] SCM_ADR_PIN_CAP = 32'h4004_8100;
  localparam logic [31:0] SCM_ADR_BOD = 32'h4004_8150;
  localparam logic [31:0] SCM_ADR_TICK_CAL = 32'h4004_8154;
  localparam logic [31:0] SCM_ADR_LATENCY = 32'h4004_8170;
  localparam logic [31:0] SCM_ADR_NMI = 32'h4004_8174;
  localparam logic [31:0] SCM_ADR_IRQ_STAT = 32'h4004_81F0;
  localparam logic [31:0] SCM_ADR_IRQ_MASK = 32'h4004_81F4;

  // Field widths and positions
  localparam int SCM_NUM_W = 8;
  localparam int SCM_DEN_W = 8;
  localparam int SCM_FSRC_W = 2;
  localparam int SCM_CSEL_W = 3;
  localparam int SCM_CDIV_W = 8;
  localparam int SCM_CAL_W = 26;
  localparam int SCM_LAT_W = 8;
  localparam int SCM_NMI_NUM_W = 5;
  localparam int SCM_NMI_EN_BIT = 31;
  localparam int SCM_BOD_RLEV_LSB = 0;
  localparam int SCM_BOD_ILEV_LSB = 2;
  localparam int SCM_BOD_REN_BIT = 4;
  localparam int SCM_ST_W = 2;
  localparam int SCM_ST_BOD_INT = 0;
  localparam int SCM_ST_BOD_RST = 1;

  // Reset values
  localparam logic [7:0] SCM_RST_NUM = 8'h00;
  localparam logic [7:0] SCM_RST_DEN = 8'h00;
  localparam logic [1:0] SCM_RST_FSRC = 2'h0;
  localparam logic [2:0] SCM_RST_CSEL = 3'h0;
  localparam logic [7:0] SCM_RST_CDIV = 8'h00;
  localparam logic [1:0] SCM_RST_BOD_LEV = 2'h0;
  localparam logic SCM_RST_BOD_REN = 1'b1;
  localparam logic [25:0] SCM_RST_CAL = 26'h000_0000;
  localparam logic [7:0] SCM_RST_LAT = 8'h10;

  // Source codes
  localparam logic [1:0] SCM_FSRC_FRO = 2'h0;
  localparam logic [1:0] SCM_FSRC_MAIN = 2'h1;
  localparam logic [1:0] SCM_FSRC_NONE = 2'h3;
  localparam logic [2:0] SCM_CSEL_FRO = 3'h0;
  localparam logic [2:0] SCM_CSEL_MAIN = 3'h1;
  localparam logic [2:0] SCM_CSEL_EXT = 3'h3;
  localparam logic [2:0] SCM_CSEL_LPOSC = 3'h4;
  localparam logic [2:0] SCM_CSEL_NONE = 3'h7;

  // Fractional generator
  localparam logic [7:0] SCM_DEN_SUPPORTED = 8'hFF;
  localparam logic [8:0] SCM_FRAC_WRAP = 9'h100;

endpackage

// *** hw/scm_clock_output_pin_div.sv ***
// Integer divider of source ticks for the clock output pin
`timescale 1ns/1ns
`default_nettype none
module scm_clock_output_pin_div
  import scm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Source and setting
  input wire logic src_tick_i,
  input wire logic [SCM_CDIV_W-1:0] div_i,
  // Divided output
  output logic tick_o
);

  typedef struct packed {
    logic [SCM_CDIV_W-1:0] cnt;
    logic tick;
  } scm_div_state_t;

  scm_div_state_t st;
  scm_div_state_t next_st;

  always_comb begin
    next_st = st;
    if (ce_i) begin
      next_st.tick = 1'b0;
      if (div_i == '0) begin
        next_st.cnt = '0;
      end else if (src_tick_i) begin
        if (st.cnt + 8'h01 >= div_i) begin
          next_st.cnt = '0;
          next_st.tick = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end
    end
    if (rst_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign tick_o = st.tick;

endmodule
`default_nettype wire

// *** hw/scm_regs.sv ***
// Clock, brown-out, calibration, latency and non-maskable source register bank
// Summary of operation
// - numerator register keeps 8 bits; divider uses the written value unchanged.
// - generator source 2-bit: oscillator, main clock, reserved, none; resets to oscillator.
// - clock output source 3-bit: oscillator, main, external, low power, none; resets zero.
// - output divider 8-bit; zero stops the output, N divides the source by N.
// - pin levels at power-on reset kept in a 32-bit read-only register.
// - brown-out interrupt level codes 1..3; falling below it raises an interrupt.
// - brown-out reset level 2-bit field, only code 0 defined, resets zero; codes 1..3 still pick comparators 1..3.
// - bit 4 enables the brown-out reset, resets set; both events wake the chip.
// - 26-bit tick calibration value, resets zero, drives the tick timer calibration.
// - 8-bit interrupt latency floor, cycles 0..255, resets to 0x10.
// - software picks one peripheral interrupt line forwarded as non-maskable.
// - non-maskable number is 5 bits; acts only while bit 31 is set.
// - generator output is source over one plus numerator/denominator; denominator 0xFF.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module scm_regs
  import scm_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Clock source ticks
  input wire logic fro_tick_i,
  input wire logic main_tick_i,
  input wire logic ext_tick_i,
  input wire logic lposc_tick_i,
  // Port pins, supply comparators, peripheral interrupts
  input wire logic [31:0] pins_i,
  input wire logic [3:0] bod_below_i,
  input wire logic [31:0] irq_lines_i,
  // Generated clocks
  output logic frac_tick_o,
  output logic clock_output_pin_tick_o,
  // Brown-out and interrupt outputs
  output logic bod_irq_o,
  output logic bod_reset_o,
  output logic wake_o,
  output logic nmi_o,
  output logic irq_o,
  // Static settings for the core
  output logic [SCM_CAL_W-1:0] tick_calibration_o,
  output logic [SCM_LAT_W-1:0] latency_floor_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [SCM_NUM_W-1:0] numerator_value;
    logic [SCM_DEN_W-1:0] fractional_gen_denominator;
    logic [SCM_FSRC_W-1:0] frac_src;
    logic [SCM_CSEL_W-1:0] clock_output_pin_src;
    logic [SCM_CDIV_W-1:0] clock_output_pin_div;
    logic [31:0] captured_pin_levels;
    logic [1:0] brownout_reset_level;
    logic [1:0] brownout_interrupt_level;
    logic brownout_reset_enable;
    logic [SCM_CAL_W-1:0] tick_cal;
    logic [SCM_LAT_W-1:0] latency;
    logic [SCM_NMI_NUM_W-1:0] nonmaskable_source_number;
    logic nonmaskable_source_enable;
    logic [SCM_ST_W-1:0] status;
    logic [SCM_ST_W-1:0] mask;
    logic [8:0] acc;
    logic frac_tick;
    logic bod_irq;
    logic bod_rst;
    logic wake;
    logic nmi;
    logic irq;
  } scm_state_t;

  scm_state_t st;
  scm_state_t next_st;
  logic clock_output_pin_src_tick;

  // Byte-lane merge of write data over the current register value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Register read view; unused bits stay zero
  function automatic logic [31:0] reg_view(input logic [31:0] adr,
                                           input scm_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (adr)
      SCM_ADR_FRAC_DEN: v[SCM_DEN_W-1:0] = s.fractional_gen_denominator;
      SCM_ADR_FRAC_NUM: v[SCM_NUM_W-1:0] = s.numerator_value;
      SCM_ADR_FRAC_SRC: v[SCM_FSRC_W-1:0] = s.frac_src;
      SCM_ADR_CO_SEL: v[SCM_CSEL_W-1:0] = s.clock_output_pin_src;
      SCM_ADR_CO_DIV: v[SCM_CDIV_W-1:0] = s.clock_output_pin_div;
      SCM_ADR_PIN_CAP: v = s.captured_pin_levels;
      SCM_ADR_BOD: begin
        v[SCM_BOD_RLEV_LSB +: 2] = s.brownout_reset_level;
        v[SCM_BOD_ILEV_LSB +: 2] = s.brownout_interrupt_level;
        v[SCM_BOD_REN_BIT] = s.brownout_reset_enable;
      end
      SCM_ADR_TICK_CAL: v[SCM_CAL_W-1:0] = s.tick_cal;
      SCM_ADR_LATENCY: v[SCM_LAT_W-1:0] = s.latency;
      SCM_ADR_NMI: begin
        v[SCM_NMI_NUM_W-1:0] = s.nonmaskable_source_number;
        v[SCM_NMI_EN_BIT] = s.nonmaskable_source_enable;
      end
      SCM_ADR_IRQ_STAT: v[SCM_ST_W-1:0] = s.status;
      SCM_ADR_IRQ_MASK: v[SCM_ST_W-1:0] = s.mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Source picker for the fractional generator
  function automatic logic frac_pick(input logic [SCM_FSRC_W-1:0] sel,
                                     input logic free_running_osc,
                                     input logic mainc);
    logic t;
    t = 1'b0;
    unique case (sel)
      SCM_FSRC_FRO: t = free_running_osc;
      SCM_FSRC_MAIN: t = mainc;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Source picker for the clock output; reserved codes give no clock
  function automatic logic clock_output_pin_pick(input logic [SCM_CSEL_W-1:0] sel,
                                       input logic free_running_osc,
                                       input logic mainc,
                                       input logic ext,
                                       input logic lposc);
    logic t;
    t = 1'b0;
    unique case (sel)
      SCM_CSEL_FRO: t = free_running_osc;
      SCM_CSEL_MAIN: t = mainc;
      SCM_CSEL_EXT: t = ext;
      SCM_CSEL_LPOSC: t = lposc;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Comparator output for one brown-out level code
  function automatic logic supply_below(input logic [3:0] below,
                                        input logic [1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (code == 2'(i)) begin
        hit = below[i];
      end
    end
    return hit;
  endfunction

  // Request taken on an idle bus; its write lands one edge later, while ack stands,
  // so a master that samples ack at an edge sees the write take effect at that edge
  logic bus_take;
  logic bus_write;
  logic [SCM_ST_W-1:0] status_clr;
  assign bus_take = cyc_i && stb_i && !st.ack;
  assign bus_write = cyc_i && stb_i && st.ack && we_i;

  // Write-one-to-clear strobe per status bit, only from a written byte lane
  for (genvar i = 0; i < SCM_ST_W; i++) begin : g_status_clr
    assign status_clr[i] = dat_i[i] && sel_i[i / 8];
  end

  always_comb begin
    logic [31:0] wdat;
    logic frac_src_tick;
    logic below_int;
    logic below_rst;
    logic [SCM_ST_W-1:0] events;
    wdat = lane_merge(reg_view(adr_i, st), dat_i, sel_i);
    frac_src_tick = frac_pick(st.frac_src, fro_tick_i, main_tick_i);
    below_int = 1'b0;
    below_rst = 1'b0;
    events = '0;
    next_st = st;
    // A low enable freezes everything, the bus answer included
    if (ce_i) begin
      next_st.ack = 1'b0;
      next_st.frac_tick = 1'b0;
      if (bus_take) begin
        next_st.ack = 1'b1;
        next_st.rdat = reg_view(adr_i, st);
      end
      // The write lands on the edge at which the master samples ack high
      if (bus_write) begin
        unique case (adr_i)
          SCM_ADR_FRAC_DEN: begin
            // Any value is kept; only the supported one lets the generator run
            next_st.fractional_gen_denominator = wdat[SCM_DEN_W-1:0];
          end
          SCM_ADR_FRAC_NUM: begin
            next_st.numerator_value = wdat[SCM_NUM_W-1:0];
          end
          SCM_ADR_FRAC_SRC: begin
            next_st.frac_src = wdat[SCM_FSRC_W-1:0];
          end
          SCM_ADR_CO_SEL: begin
            next_st.clock_output_pin_src = wdat[SCM_CSEL_W-1:0];
          end
          SCM_ADR_CO_DIV: begin
            next_st.clock_output_pin_div = wdat[SCM_CDIV_W-1:0];
          end
          SCM_ADR_PIN_CAP: begin
            // Read-only: the capture only changes at power-on reset
            next_st.captured_pin_levels = st.captured_pin_levels;
          end
          SCM_ADR_BOD: begin
            // The reserved interrupt code is kept as written; it never fires
            next_st.brownout_reset_level = wdat[SCM_BOD_RLEV_LSB +: 2];
            next_st.brownout_interrupt_level = wdat[SCM_BOD_ILEV_LSB +: 2];
            next_st.brownout_reset_enable = wdat[SCM_BOD_REN_BIT];
          end
          SCM_ADR_TICK_CAL: begin
            next_st.tick_cal = wdat[SCM_CAL_W-1:0];
          end
          SCM_ADR_LATENCY: begin
            next_st.latency = wdat[SCM_LAT_W-1:0];
          end
          SCM_ADR_NMI: begin
            // Software is expected to disable before changing the number
            next_st.nonmaskable_source_number = wdat[SCM_NMI_NUM_W-1:0];
            next_st.nonmaskable_source_enable = wdat[SCM_NMI_EN_BIT];
          end
          SCM_ADR_IRQ_STAT: begin
            // A lane left out of the write must not clear its bits
            next_st.status = st.status & ~status_clr;
          end
          SCM_ADR_IRQ_MASK: begin
            next_st.mask = wdat[SCM_ST_W-1:0];
          end
          default: begin
            next_st.status = next_st.status;
          end
        endcase
      end

      // Fractional generator: swallow source ticks so that, per 256+N source
      // ticks, 256 pass. An unsupported denominator stops the generator.
      if (st.fractional_gen_denominator != SCM_DEN_SUPPORTED) begin
        next_st.acc = '0;
      end else if (frac_src_tick) begin
        if (st.acc[8]) begin
          next_st.acc = st.acc - SCM_FRAC_WRAP;
        end else begin
          next_st.acc = st.acc + {1'b0, st.numerator_value};
          next_st.frac_tick = 1'b1;
        end
      end

      // Brown-out: code 0 of the interrupt level is reserved and never fires
      if (st.brownout_interrupt_level != 2'h0) begin
        below_int = supply_below(bod_below_i, st.brownout_interrupt_level);
      end
      below_rst = st.brownout_reset_enable
                  && supply_below(bod_below_i, st.brownout_reset_level);
      next_st.bod_irq = below_int;
      next_st.bod_rst = below_rst;
      next_st.wake = below_int || below_rst;
      events[SCM_ST_BOD_INT] = below_int && !st.bod_irq;
      events[SCM_ST_BOD_RST] = below_rst && !st.bod_rst;
      // A new event wins over a clear in the same cycle
      next_st.status = next_st.status | events;
      next_st.irq = |(next_st.status & next_st.mask);

      next_st.nmi = st.nonmaskable_source_enable
                    && irq_lines_i[st.nonmaskable_source_number];
    end

    // Power-on reset: pin levels are caught on every reset edge
    if (rst_i) begin
      next_st = '0;
      next_st.captured_pin_levels = pins_i;
      next_st.numerator_value = SCM_RST_NUM;
      next_st.fractional_gen_denominator = SCM_RST_DEN;
      next_st.frac_src = SCM_RST_FSRC;
      next_st.clock_output_pin_src = SCM_RST_CSEL;
      next_st.clock_output_pin_div = SCM_RST_CDIV;
      next_st.brownout_reset_level = SCM_RST_BOD_LEV;
      next_st.brownout_interrupt_level = SCM_RST_BOD_LEV;
      next_st.brownout_reset_enable = SCM_RST_BOD_REN;
      next_st.tick_cal = SCM_RST_CAL;
      next_st.latency = SCM_RST_LAT;
      // Sticky events and their mask start clear, so no interrupt follows reset
      next_st.status = '0;
      next_st.mask = '0;
    end
  end

  // The only register stage besides the divider's; enable and reset both act through next_st
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // The picked tick feeds the divider, which registers its own output pulse
  assign clock_output_pin_src_tick = clock_output_pin_pick(st.clock_output_pin_src, fro_tick_i, main_tick_i,
                                       ext_tick_i, lposc_tick_i);

  scm_clock_output_pin_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_tick_i(clock_output_pin_src_tick),
    .div_i(st.clock_output_pin_div),
    .tick_o(clock_output_pin_tick_o)
  );

  // Every output below is a field of the registered state
  assign dat_o = st.rdat;
  assign ack_o = st.ack;
  assign frac_tick_o = st.frac_tick;
  assign bod_irq_o = st.bod_irq;
  assign bod_reset_o = st.bod_rst;
  assign wake_o = st.wake;
  assign nmi_o = st.nmi;
  assign irq_o = st.irq;
  assign tick_calibration_o = st.tick_cal;
  assign latency_floor_o = st.latency;

endmodule
`default_nettype wire

// *** tb/scm_regs_assertions.sv ***
// Port-level checks of the clock and miscellaneous register bank
`timescale 1ns/1ns
`default_nettype none
module scm_regs_assertions
  import scm_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Sources, events and outputs
  input wire logic fro_tick_i,
  input wire logic main_tick_i,
  input wire logic ext_tick_i,
  input wire logic lposc_tick_i,
  input wire logic [3:0] bod_below_i,
  input wire logic [31:0] irq_lines_i,
  input wire logic frac_tick_o,
  input wire logic clock_output_pin_tick_o,
  input wire logic bod_irq_o,
  input wire logic bod_reset_o,
  input wire logic wake_o,
  input wire logic nmi_o,
  input wire logic [SCM_CAL_W-1:0] tick_calibration_o,
  input wire logic [SCM_LAT_W-1:0] latency_floor_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic no_src;
  assign no_src = !(fro_tick_i || main_tick_i || ext_tick_i || lposc_tick_i);
  // Reset checks run while reset is high, so they opt out of the default disable
  chk_latency_reset: assert property (disable iff (1'b0) rst_i |=> latency_floor_o == 8'h10)
    else $error("latency floor not at reset value");
  chk_cal_reset: assert property (disable iff (1'b0) rst_i |=> tick_calibration_o == '0)
    else $error("calibration not cleared by reset");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("request not answered next cycle");
  chk_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_nmi_quiet: assert property (ce_i && irq_lines_i == '0 |=> !nmi_o)
    else $error("nmi without any interrupt line");
  chk_bod_quiet: assert property (ce_i && bod_below_i == '0 |=> !bod_irq_o && !bod_reset_o)
    else $error("brown-out output without low supply");
  chk_wake_src: assert property (wake_o == (bod_irq_o || bod_reset_o))
    else $error("wake does not follow brown-out events");
  chk_clock_output_pin_src: assert property (ce_i && no_src |=> !clock_output_pin_tick_o)
    else $error("clock output tick without source tick");
  chk_frac_src: assert property (ce_i && !fro_tick_i && !main_tick_i |=> !frac_tick_o)
    else $error("fractional tick without source tick");
  cover property (clock_output_pin_tick_o);
  cover property (nmi_o);
  cover property (bod_irq_o && wake_o);
endmodule
bind scm_regs scm_regs_assertions u_chk (.*);
`default_nettype wire

// *** tb/scm_regs_bench.sv ***
// Self-checking bench of the clock and miscellaneous register bank
`timescale 1ns/1ns
`default_nettype none
module scm_regs_bench import scm_pkg::*; ;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic fro_tick_i = 1'b0, main_tick_i = 1'b0, ext_tick_i = 1'b0, lposc_tick_i = 1'b0;
  logic [31:0] adr_i = '0, dat_i = '0, pins_i = '0, irq_lines_i = '0, dat_o, rd, cap;
  logic [3:0] sel_i = 4'hF, bod_below_i = 4'h0;
  logic frac_tick_o, clock_output_pin_tick_o, bod_irq_o, bod_reset_o, wake_o, nmi_o, irq_o, ack_o;
  logic [SCM_CAL_W-1:0] tick_calibration_o;
  logic [SCM_LAT_W-1:0] latency_floor_o;
  int err_count = 0, num_checks = 0, fc, cc;
  logic [31:0] adrs [9] = '{SCM_ADR_FRAC_DEN, SCM_ADR_FRAC_NUM, SCM_ADR_FRAC_SRC,
    SCM_ADR_CO_SEL, SCM_ADR_CO_DIV, SCM_ADR_BOD, SCM_ADR_TICK_CAL, SCM_ADR_LATENCY, SCM_ADR_NMI};
  logic [31:0] msks [9] = '{32'hFF, 32'hFF, 32'h3, 32'h7, 32'hFF, 32'h1F, 32'h3FF_FFFF,
    32'hFF, 32'h8000_001F};
  logic [31:0] shd [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h0, 32'h10, 32'h0};
  int divs [3] = '{0, 1, 4};
  scm_regs dut (.*);
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] s, logic [31:0] m);
    for (int b = 0; b < 4; b++)
      if (s[b]) o[8*b+:8] = n[8*b+:8];
    return o & m;
  endfunction
  // Source pulses per burst: oscillator 12, main 6, external 9, low power 15
  function automatic int co_exp(int c, int n);
    int p;
    p = c == 0 ? 12 : c == 1 ? 6 : c == 3 ? 9 : c == 4 ? 15 : 0;
    return n == 0 ? 0 : p / n;
  endfunction
  function automatic int fr_exp(logic [7:0] den, int c, int n);
    if (den != 8'hFF || c > 1) return 0;
    return (c == 0 ? 12 : 6) * 256 / (256 + n);
  endfunction
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The request stands until the edge that samples ack high; read data is taken there
  task automatic wb(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic rd_reg(logic [31:0] a);
    wb(1'b0, a, '0, 4'hF);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic burst();
    fc = 0;
    cc = 0;
    for (int c = 0; c < 20; c++) begin
      @(posedge clk_i);
      fro_tick_i <= c < 12;
      main_tick_i <= c < 6;
      ext_tick_i <= c < 9;
      lposc_tick_i <= c < 15;
      @(negedge clk_i);
      fc += frac_tick_o;
      cc += clock_output_pin_tick_o;
    end
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    pins_i <= $urandom();
    repeat (6) @(posedge clk_i);
    cap = pins_i;
    rst_i <= 1'b0;
    pins_i <= ~pins_i;
    rd_reg(SCM_ADR_PIN_CAP);
    check("pin capture", cap, rd);
    rd_reg(SCM_ADR_LATENCY);
    check("latency after reset", 32'h10, rd);
  endtask
  initial begin
    int k, e;
    logic [31:0] d;
    logic [3:0] s;
    logic [7:0] den, n;
    void'($urandom(59));
    do_reset();
    wr(SCM_ADR_PIN_CAP, ~cap);
    rd_reg(SCM_ADR_PIN_CAP);
    check("capture after write", cap, rd);
    wr(32'h4004_8104, '1);
    rd_reg(32'h4004_8104);
    check("unmapped", '0, rd);
    for (int i = 0; i < 9; i++) begin
      rd_reg(adrs[i]);
      check("reset value", shd[i], rd);
    end
    // All-ones first shows every reserved bit, then random data and lanes
    for (int j = 0; j < 49; j++) begin
      k = j < 9 ? j : $urandom_range(8);
      d = j < 9 ? '1 : $urandom();
      s = j < 9 ? 4'hF : 4'($urandom());
      wb(1'b1, adrs[k], d, s);
      shd[k] = merge(shd[k], d, s, msks[k]);
      rd_reg(adrs[k]);
      check("readback", shd[k], rd);
    end
    check("calibration out", shd[6], 32'(tick_calibration_o));
    check("latency out", shd[7], 32'(latency_floor_o));
    foreach (divs[q]) begin
      for (int c = 0; c < 8; c++) begin
        wr(SCM_ADR_CO_DIV, '0);
        wr(SCM_ADR_CO_SEL, 32'(c));
        wr(SCM_ADR_CO_DIV, 32'(divs[q]));
        burst();
        check("clock output ticks", 32'(co_exp(c, divs[q])), 32'(cc));
      end
    end
    // A low clock enable must hold both generators still
    wr(SCM_ADR_CO_SEL, 32'(SCM_CSEL_FRO));
    ce_i <= 1'b0;
    burst();
    @(posedge clk_i);
    ce_i <= 1'b1;
    check("clock output frozen", '0, 32'(cc));
    check("fractional frozen", '0, 32'(fc));
    for (int j = 0; j < 6; j++) begin
      k = j % 3 == 2 ? 3 : j % 3;
      n = j == 0 ? 8'h00 : j == 1 ? 8'hFF : 8'($urandom());
      den = j == 5 ? 8'h7F : SCM_DEN_SUPPORTED;
      wr(SCM_ADR_FRAC_DEN, 32'(den));
      wr(SCM_ADR_FRAC_NUM, 32'(n));
      wr(SCM_ADR_FRAC_SRC, 32'(k));
      burst();
      e = fr_exp(den, k, n);
      // Accumulator phase left by earlier bursts shifts the count by one at most
      if (e > 0 && fc >= e - 1 && fc <= e + 1) fc = e;
      check("fractional ticks", 32'(e), 32'(fc));
    end
    wr(SCM_ADR_IRQ_MASK, '0);
    wr(SCM_ADR_BOD, 32'h18);
    wr(SCM_ADR_IRQ_STAT, 32'h3);
    bod_below_i <= 4'h5;
    settle();
    check("bod level two", 32'h7, 32'({bod_irq_o, bod_reset_o, wake_o}));
    check("irq masked", '0, 32'(irq_o));
    wr(SCM_ADR_BOD, 32'h14);
    settle();
    check("bod level one", 32'h3, 32'({bod_irq_o, bod_reset_o, wake_o}));
    rd_reg(SCM_ADR_IRQ_STAT);
    check("status", 32'h3, rd);
    wr(SCM_ADR_IRQ_MASK, 32'h1);
    settle();
    check("irq unmasked", 32'h1, 32'(irq_o));
    wr(SCM_ADR_IRQ_STAT, 32'h1);
    settle();
    check("irq cleared", '0, 32'(irq_o));
    rd_reg(SCM_ADR_IRQ_STAT);
    check("status cleared", 32'h2, rd);
    wr(SCM_ADR_BOD, '0);
    bod_below_i <= 4'hF;
    settle();
    check("bod off", '0, 32'({bod_irq_o, bod_reset_o, wake_o}));
    repeat (3) begin
      k = $urandom_range(31);
      wr(SCM_ADR_NMI, '0);
      wr(SCM_ADR_NMI, 32'(k));
      wr(SCM_ADR_NMI, 32'h8000_0000 | 32'(k));
      irq_lines_i <= 32'h1 << k;
      settle();
      check("nmi selected", 32'h1, 32'(nmi_o));
      wr(SCM_ADR_NMI, 32'(k));
      settle();
      check("nmi disabled", '0, 32'(nmi_o));
      wr(SCM_ADR_NMI, 32'h8000_0000 | 32'(k));
      irq_lines_i <= ~(32'h1 << k);
      settle();
      check("nmi other line", '0, 32'(nmi_o));
    end
    do_reset();
    finish_test();
  end
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
